// ==== logic/fcl_pkg.sv ====
// Purpose: Shared constants and types for the flow correction and logic blocks
// Assumes: Values are signed fixed point, FCL_FRAC fraction bits, 1.0 = 100 %
// Notes: Register offsets are byte addresses on the APB port

package fcl_pkg;
    localparam int unsigned FCL_FRAC = 16;
    localparam logic [31:0] FCL_ONE = 32'h0001_0000;
    localparam logic [31:0] FCL_HALF = 32'h0000_8000;
    localparam logic [31:0] FCL_QSTART_MIN = 32'h0000_0290;
    localparam logic [31:0] FCL_QEND_MAX = 32'h0063_fd5c;
    localparam logic [31:0] FCL_HYST_RST = 32'h0000_0ccd;
    localparam logic [31:0] FCL_QUOT_RST = 32'h0001_0000;
    localparam logic [31:0] FCL_SAT_MAX = 32'h7fff_ffff;

    localparam int unsigned FCL_N_SEL = 5;
    localparam int unsigned FCL_N_CMP = 2;
    localparam int unsigned FCL_N_NAND = 2;
    localparam int unsigned FCL_CYCLE_TICKS_RST = 1000;
    localparam int unsigned FCL_DIV_BITS = 48;
    localparam int unsigned FCL_ROOT_BITS = 64;

    localparam logic [7:0] FCL_OFS_CTRL = 8'h00;
    localparam logic [7:0] FCL_OFS_STATUS = 8'h04;
    localparam logic [7:0] FCL_OFS_PSTART = 8'h08;
    localparam logic [7:0] FCL_OFS_PEND = 8'h0c;
    localparam logic [7:0] FCL_OFS_TSTART = 8'h10;
    localparam logic [7:0] FCL_OFS_TEND = 8'h14;
    localparam logic [7:0] FCL_OFS_CORR_IN1 = 8'h18;
    localparam logic [7:0] FCL_OFS_CORR_IN2 = 8'h1c;
    localparam logic [7:0] FCL_OFS_CORR_IN3 = 8'h20;
    localparam logic [7:0] FCL_OFS_CORR_OUT = 8'h24;
    localparam logic [3:0] FCL_SLOT_SEL = 4'h4;
    localparam logic [3:0] FCL_SLOT_CMP = 4'ha;
    localparam logic [3:0] FCL_SLOT_NAND = 4'hc;

    localparam int unsigned FCL_CTRL_RUN = 0;
    localparam int unsigned FCL_STAT_BUSY = 0;
    localparam int unsigned FCL_STAT_DEN_ERR = 1;

    typedef enum logic [1:0]
    {
        FCL_IDLE = 2'b00,
        FCL_DIVIDE = 2'b01,
        FCL_ROOT = 2'b11
    } fcl_phase_e;

    typedef struct packed
    {
        logic access;
        logic commit;
        logic [7:0] addr;
        logic [31:0] wdata;
    } fcl_apb_req_s;
endpackage

// ==== logic/fcl_divider.sv ====
// Purpose: Unsigned restoring divider, one quotient bit per clock
// Assumes: Divisor is nonzero at start; start is a one-cycle pulse
// Notes: Result stays on quotient until the next start

`timescale 1ns/1ps

module fcl_divider
    import fcl_pkg::*;
#(
    parameter int unsigned NW = FCL_DIV_BITS,
    parameter int unsigned DW = 32
)
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, active low
    input wire logic start, // Load operands and begin
    input wire logic [NW-1:0] dividend, // Numerator
    input wire logic [DW-1:0] divisor, // Denominator
    output logic busy, // Division in progress
    output logic done, // One-cycle end pulse
    output logic [NW-1:0] quotient // Result
);
    typedef struct packed
    {
        logic [DW:0] rem;
        logic [NW-1:0] quo;
        logic [DW-1:0] den;
        logic [7:0] cnt;
        logic busy;
        logic done;
    } fcl_div_s;

    fcl_div_s st;
    fcl_div_s nx;
    logic [DW:0] trial;

    // Refused at elaboration, so a bad width never reaches a netlist
    if (NW < 2 || NW > 255 || DW < 2)
    begin : g_bad_width
        $error("fcl_divider: width out of range");
    end

    always_comb
    begin
        nx = st;
        nx.done = 1'b0;
        trial = {st.rem[DW-1:0], st.quo[NW-1]};
        if (start)
        begin
            nx.rem = '0;
            nx.quo = dividend;
            nx.den = divisor;
            nx.cnt = 8'(NW);
            nx.busy = 1'b1;
        end
        else if (st.busy)
        begin
            if (trial >= {1'b0, st.den})
            begin
                nx.rem = trial - {1'b0, st.den};
                nx.quo = {st.quo[NW-2:0], 1'b1};
            end
            else
            begin
                nx.rem = trial;
                nx.quo = {st.quo[NW-2:0], 1'b0};
            end
            nx.cnt = st.cnt - 8'h01;
            if (st.cnt == 8'h01)
            begin
                nx.busy = 1'b0;
                nx.done = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '0;
        else
            st <= nx;
    end

    assign busy = st.busy;
    assign done = st.done;
    assign quotient = st.quo;
endmodule // fcl_divider

// ==== logic/fcl_sqrt.sv ====
// Purpose: Integer square root, digit by digit, one root bit per clock
// Assumes: start is a one-cycle pulse
// Notes: Root is floor(sqrt(radicand)); held until the next start

`timescale 1ns/1ps

module fcl_sqrt
    import fcl_pkg::*;
#(
    parameter int unsigned W = FCL_ROOT_BITS
)
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, active low
    input wire logic start, // Load radicand and begin
    input wire logic [W-1:0] radicand, // Value to root
    output logic done, // One-cycle end pulse
    output logic [W/2-1:0] root // Result
);
    localparam int unsigned RW = W / 2;

    typedef struct packed
    {
        logic [RW+1:0] rem;
        logic [RW-1:0] root;
        logic [W-1:0] rad;
        logic [7:0] cnt;
        logic busy;
        logic done;
    } fcl_sqrt_s;

    fcl_sqrt_s st;
    fcl_sqrt_s nx;
    logic [RW+3:0] part;
    logic [RW+3:0] trial;

    if (W < 4 || W > 254 || (W % 2) != 0)
    begin : g_bad_width
        $error("fcl_sqrt: width must be even, 4..254");
    end

    always_comb
    begin
        nx = st;
        nx.done = 1'b0;
        part = {st.rem, st.rad[W-1:W-2]};
        trial = {2'b00, st.root, 2'b01};
        if (start)
        begin
            nx.rem = '0;
            nx.root = '0;
            nx.rad = radicand;
            nx.cnt = 8'(RW);
            nx.busy = 1'b1;
        end
        else if (st.busy)
        begin
            if (part >= trial)
            begin
                nx.rem = RW'(0) + (part[RW+1:0] - trial[RW+1:0]);
                nx.root = {st.root[RW-2:0], 1'b1};
            end
            else
            begin
                nx.rem = part[RW+1:0];
                nx.root = {st.root[RW-2:0], 1'b0};
            end
            nx.rad = {st.rad[W-3:0], 2'b00};
            nx.cnt = st.cnt - 8'h01;
            if (st.cnt == 8'h01)
            begin
                nx.busy = 1'b0;
                nx.done = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '0;
        else
            st <= nx;
    end

    assign done = st.done;
    assign root = st.root;
endmodule // fcl_sqrt

// ==== logic/fcl_blocks.sv ====
// Purpose: Gas flow corrector, analog selectors, hysteresis comparators, NAND blocks
// Assumes: APB slave on pclk; values signed Q16 where 1.0 = 100 %
// Notes: All blocks evaluate once per controller cycle tick while run is set
// Contract
// - Output is rooted input times correction root
// - Start quotients 0.01..1, end 1..99.99, clamped
// - Rooted pressure input clamped to zero minimum
// - Selector: first below 0.5, second otherwise
// - Comparator sets above plus half, clears below
// - NAND output low only when all high
// - Default NAND inputs make plain inverter
// - Logic inputs true at or above 0.5
// - Logic outputs are 0 % or 100 %
//
// The address map and the APB interface to the registers were left to the implementer.

`timescale 1ns/1ps

module fcl_blocks
    import fcl_pkg::*;
#(
    parameter int unsigned CYCLE_TICKS = FCL_CYCLE_TICKS_RST
)
(
    input wire logic pclk, // Clock, 125 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    output logic [FCL_N_CMP-1:0] limit_level // Comparator outputs as levels
);
    typedef struct packed
    {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic run;
        logic err_den;
        logic [15:0] tick_cnt;
        fcl_phase_e phase;
        logic div_start;
        logic root_start;
        logic [47:0] div_num;
        logic [31:0] div_den;
        logic [31:0] dp_hold;
        logic [3:0][31:0] quot;
        logic [2:0][31:0] corr_in;
        logic [31:0] corr_out;
        logic [FCL_N_SEL-1:0][3:0][31:0] sel;
        logic [FCL_N_CMP-1:0][3:0][31:0] cmp;
        logic [FCL_N_NAND-1:0][3:0][31:0] nnd;
        logic [FCL_N_CMP-1:0] limit;
    } fcl_core_s;

    fcl_core_s st;
    fcl_core_s nx;
    fcl_apb_req_s req;
    logic tick;
    logic tick_run;
    logic hit;
    logic [31:0] rd;
    logic div_done;
    logic [47:0] div_q;
    logic root_done;
    logic [31:0] root_val;
    logic signed [65:0] p_num;
    logic signed [65:0] t_den;
    logic [31:0] dp_clamped;
    logic [63:0] fprod;
    logic [31:0] corr_sat;
    logic signed [33:0] cmp_e1 [FCL_N_CMP];
    logic signed [33:0] cmp_up [FCL_N_CMP];
    logic signed [33:0] cmp_dn [FCL_N_CMP];

    // A shorter cycle could tick while the last correction still runs, and that tick is skipped
    if (CYCLE_TICKS < 100 || CYCLE_TICKS > 65536)
    begin : g_bad_ticks
        $error("fcl_blocks: CYCLE_TICKS must allow a full correction, 100..65536");
    end

    function automatic logic is_true(input logic [31:0] v);
        return $signed(v) >= $signed(FCL_HALF);
    endfunction

    function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
                                          input logic [31:0] hi);
        if ($signed(v) < $signed(lo))
            return lo;
        else if ($signed(v) > $signed(hi))
            return hi;
        return v;
    endfunction

    function automatic logic [31:0] sat_pos(input logic signed [65:0] v);
        if (v <= 66'sd0)
            return 32'h0000_0000;
        else if (v > $signed({34'h0, FCL_SAT_MAX}))
            return FCL_SAT_MAX;
        return v[31:0];
    endfunction

    fcl_divider #(.NW(FCL_DIV_BITS), .DW(32)) u_div
    (
        .pclk(pclk),
        .presetn(presetn),
        .start(st.div_start),
        .dividend(st.div_num),
        .divisor(st.div_den),
        .busy(),
        .done(div_done),
        .quotient(div_q)
    );

    fcl_sqrt #(.W(FCL_ROOT_BITS)) u_sqrt
    (
        .pclk(pclk),
        .presetn(presetn),
        .start(st.root_start),
        .radicand({div_q, 16'h0000}),
        .done(root_done),
        .root(root_val)
    );

    always_comb
    begin
        nx = st;
        nx.div_start = 1'b0;
        nx.root_start = 1'b0;
        req.access = psel & penable & ~st.pready;
        req.commit = psel & penable & st.pready & pwrite;
        req.addr = paddr[7:0];
        req.wdata = pwdata;
        tick = (st.tick_cnt == 16'(CYCLE_TICKS - 1));
        tick_run = tick & st.run;
        nx.tick_cnt = tick ? 16'h0000 : st.tick_cnt + 16'h0001;

        // Address decode and read mux; block slots are 16 bytes, word 3 the output
        hit = 1'b0;
        rd = 32'h0000_0000;
        if (paddr[11:8] == 4'h0 && req.addr[1:0] == 2'b00)
        begin
            if (req.addr <= FCL_OFS_CORR_OUT)
            begin
                hit = 1'b1;
                case (req.addr)
                    FCL_OFS_CTRL: rd = {31'h0, st.run};
                    FCL_OFS_STATUS: rd = {30'h0, st.err_den, st.phase != FCL_IDLE};
                    FCL_OFS_PSTART: rd = st.quot[0];
                    FCL_OFS_PEND: rd = st.quot[1];
                    FCL_OFS_TSTART: rd = st.quot[2];
                    FCL_OFS_TEND: rd = st.quot[3];
                    FCL_OFS_CORR_IN1: rd = st.corr_in[0];
                    FCL_OFS_CORR_IN2: rd = st.corr_in[1];
                    FCL_OFS_CORR_IN3: rd = st.corr_in[2];
                    default: rd = st.corr_out;
                endcase
            end
            for (int i = 0; i < FCL_N_SEL; i++)
                if (req.addr[7:4] == FCL_SLOT_SEL + 4'(i))
                begin
                    hit = 1'b1;
                    rd = st.sel[i][req.addr[3:2]];
                end
            for (int i = 0; i < FCL_N_CMP; i++)
                if (req.addr[7:4] == FCL_SLOT_CMP + 4'(i))
                begin
                    hit = 1'b1;
                    rd = st.cmp[i][req.addr[3:2]];
                end
            for (int i = 0; i < FCL_N_NAND; i++)
                if (req.addr[7:4] == FCL_SLOT_NAND + 4'(i))
                begin
                    hit = 1'b1;
                    rd = st.nnd[i][req.addr[3:2]];
                end
        end

        // One wait state: pready rises in the second access cycle
        nx.pready = req.access;
        nx.pslverr = req.access & ~hit;
        nx.prdata = req.access && hit ? rd : 32'h0000_0000;

        if (req.commit && hit)
        begin
            case (req.addr)
                FCL_OFS_CTRL: nx.run = req.wdata[FCL_CTRL_RUN];
                FCL_OFS_STATUS: nx.err_den = st.err_den & ~req.wdata[FCL_STAT_DEN_ERR];
                FCL_OFS_PSTART: nx.quot[0] = clamp(req.wdata, FCL_QSTART_MIN, FCL_ONE);
                FCL_OFS_PEND: nx.quot[1] = clamp(req.wdata, FCL_ONE, FCL_QEND_MAX);
                FCL_OFS_TSTART: nx.quot[2] = clamp(req.wdata, FCL_QSTART_MIN, FCL_ONE);
                FCL_OFS_TEND: nx.quot[3] = clamp(req.wdata, FCL_ONE, FCL_QEND_MAX);
                FCL_OFS_CORR_IN1: nx.corr_in[0] = req.wdata;
                FCL_OFS_CORR_IN2: nx.corr_in[1] = req.wdata;
                FCL_OFS_CORR_IN3: nx.corr_in[2] = req.wdata;
                default: ;
            endcase
            // Output words are read-only; writes to them are dropped
            if (req.addr[3:2] != 2'b11)
            begin
                for (int i = 0; i < FCL_N_SEL; i++)
                    if (req.addr[7:4] == FCL_SLOT_SEL + 4'(i))
                        nx.sel[i][req.addr[3:2]] = req.wdata;
                for (int i = 0; i < FCL_N_CMP; i++)
                    if (req.addr[7:4] == FCL_SLOT_CMP + 4'(i))
                        nx.cmp[i][req.addr[3:2]] = req.wdata;
                for (int i = 0; i < FCL_N_NAND; i++)
                    if (req.addr[7:4] == FCL_SLOT_NAND + 4'(i))
                        nx.nnd[i][req.addr[3:2]] = req.wdata;
            end
        end

        // Logic blocks, evaluated once per controller cycle
        for (int i = 0; i < FCL_N_CMP; i++)
        begin
            cmp_e1[i] = 34'($signed(st.cmp[i][0]));
            cmp_up[i] = 34'($signed(st.cmp[i][1]));
            cmp_dn[i] = 34'($signed(st.cmp[i][2]));
            if (cmp_dn[i] < 34'sd0)
                cmp_dn[i] = -cmp_dn[i];
            cmp_dn[i] = cmp_dn[i] >>> 1;
            cmp_up[i] = cmp_up[i] + cmp_dn[i];
            cmp_dn[i] = cmp_up[i] - (cmp_dn[i] <<< 1);
        end
        if (tick_run)
        begin
            for (int i = 0; i < FCL_N_SEL; i++)
                nx.sel[i][3] = is_true(st.sel[i][2]) ? st.sel[i][1] : st.sel[i][0];
            for (int i = 0; i < FCL_N_CMP; i++)
            begin
                if (cmp_e1[i] >= cmp_up[i])
                    nx.limit[i] = 1'b1;
                else if (cmp_e1[i] < cmp_dn[i])
                    nx.limit[i] = 1'b0;
                nx.cmp[i][3] = nx.limit[i] ? FCL_ONE : 32'h0000_0000;
            end
            for (int i = 0; i < FCL_N_NAND; i++)
                nx.nnd[i][3] = (is_true(st.nnd[i][0]) && is_true(st.nnd[i][1])
                                && is_true(st.nnd[i][2])) ? 32'h0000_0000 : FCL_ONE;
        end

        // Correction factor sqrt(((pe-pa)*e2+pa)/((te-ta)*e3+ta))
        p_num = ((66'($signed(st.quot[1])) - 66'($signed(st.quot[0])))
                 * 66'($signed(st.corr_in[1]))) >>> FCL_FRAC;
        p_num = p_num + 66'($signed(st.quot[0]));
        t_den = ((66'($signed(st.quot[3])) - 66'($signed(st.quot[2])))
                 * 66'($signed(st.corr_in[2]))) >>> FCL_FRAC;
        t_den = t_den + 66'($signed(st.quot[2]));
        dp_clamped = st.corr_in[0][31] ? 32'h0000_0000 : st.corr_in[0];
        fprod = 64'(st.dp_hold) * 64'(root_val);
        corr_sat = (fprod[63:47] != 17'h0) ? FCL_SAT_MAX : fprod[47:16];

        case (st.phase)
            FCL_IDLE:
                if (tick_run)
                begin
                    // A non-positive denominator has no meaning; flag it, output zero
                    if (t_den <= 66'sd0)
                    begin
                        nx.err_den = 1'b1;
                        nx.corr_out = 32'h0000_0000;
                    end
                    else
                    begin
                        nx.div_num = {sat_pos(p_num), 16'h0000};
                        nx.div_den = sat_pos(t_den);
                        nx.dp_hold = dp_clamped;
                        nx.div_start = 1'b1;
                        nx.phase = FCL_DIVIDE;
                    end
                end
            FCL_DIVIDE:
                if (div_done)
                begin
                    nx.root_start = 1'b1;
                    nx.phase = FCL_ROOT;
                end
            FCL_ROOT:
                if (root_done)
                begin
                    nx.corr_out = corr_sat;
                    nx.phase = FCL_IDLE;
                end
            default: nx.phase = FCL_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
            st.quot <= {4{FCL_QUOT_RST}};
            for (int i = 0; i < FCL_N_CMP; i++)
                st.cmp[i][2] <= FCL_HYST_RST;
            for (int i = 0; i < FCL_N_NAND; i++)
            begin
                st.nnd[i][1] <= FCL_ONE;
                st.nnd[i][2] <= FCL_ONE;
                st.nnd[i][3] <= FCL_ONE;
            end
        end
        else
            st <= nx;
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign limit_level = st.limit;

    default clocking fcl_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_corr_result;
        st.phase == FCL_ROOT && root_done |=> st.phase == FCL_IDLE && st.corr_out == $past(corr_sat);
    endproperty
    a_corr_result: assert property (p_corr_result) else $error("correction result not taken");

    property p_corr_latency;
        st.div_start |-> ##[49:51] st.phase == FCL_ROOT;
    endproperty
    a_corr_latency: assert property (p_corr_latency) else $error("division did not finish");

    property p_param_range;
        $signed(st.quot[0]) >= $signed(FCL_QSTART_MIN) && $signed(st.quot[2]) <= $signed(FCL_ONE)
        && $signed(st.quot[1]) >= $signed(FCL_ONE) && $signed(st.quot[3]) <= $signed(FCL_QEND_MAX);
    endproperty
    a_param_range: assert property (p_param_range) else $error("quotient out of span");

    property p_dp_clamp;
        st.div_start |-> !st.dp_hold[31] ##1 (!st.corr_out[31])[*3];
    endproperty
    a_dp_clamp: assert property (p_dp_clamp) else $error("negative pressure input used");

    property p_select;
        tick_run |=> st.sel[0][3] == (is_true($past(st.sel[0][2])) ? $past(st.sel[0][1])
                                                                    : $past(st.sel[0][0]));
    endproperty
    a_select: assert property (p_select) else $error("selector picked wrong input");

    property p_cmp_set;
        tick_run && cmp_e1[0] >= cmp_up[0] |=> st.limit[0] && st.cmp[0][3] == FCL_ONE;
    endproperty
    a_cmp_set: assert property (p_cmp_set) else $error("comparator failed to set");

    property p_cmp_clear;
        tick_run && cmp_e1[1] < cmp_dn[1] |=> !st.limit[1] && st.cmp[1][3] == 32'h0000_0000;
    endproperty
    a_cmp_clear: assert property (p_cmp_clear) else $error("comparator failed to clear");

    property p_cmp_hold;
        !tick_run || (cmp_e1[0] < cmp_up[0] && cmp_e1[0] >= cmp_dn[0]) |=> $stable(st.limit[0]);
    endproperty
    a_cmp_hold: assert property (p_cmp_hold) else $error("comparator changed inside band");

    property p_nand;
        tick_run |=> (st.nnd[1][3] == 32'h0000_0000) == (is_true($past(st.nnd[1][0]))
            && is_true($past(st.nnd[1][1])) && is_true($past(st.nnd[1][2])));
    endproperty
    a_nand: assert property (p_nand) else $error("nand output wrong");

    property p_nand_default;
        tick_run && st.nnd[0][1] == FCL_ONE && st.nnd[0][2] == FCL_ONE
        |=> st.nnd[0][3] == (is_true($past(st.nnd[0][0])) ? 32'h0000_0000 : FCL_ONE);
    endproperty
    a_nand_default: assert property (p_nand_default) else $error("default nand not inverting");

    property p_logic_out;
        (st.nnd[0][3] == FCL_ONE || st.nnd[0][3] == 32'h0000_0000)
        && st.cmp[1][3] == (st.limit[1] ? FCL_ONE : 32'h0000_0000);
    endproperty
    a_logic_out: assert property (p_logic_out) else $error("logic output not 0 or 100 %");
endmodule // fcl_blocks

// ==== tb/tb_flow_correction_and_logic_blocks.sv ====
// Purpose: Self-checking bench for the flow corrector and logic blocks over APB
// Assumes: Short controller cycle (100 clocks); one APB wait state per transfer
// Notes: Waits one full cycle plus margin so every block and the corrector settle

`timescale 1ns/1ps

module tb_flow_correction_and_logic_blocks;
    import fcl_pkg::*;
    localparam int TICKS = 100;
    localparam int LIMIT = 20000;
    typedef struct packed
    {
        logic [11:0] base;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] c;
        logic [31:0] q;
    } fcl_row_s;
    // Comparator rows run in order: set, hold inside band, clear, hold again
    localparam fcl_row_s ROWS [0:11] = '{
        '{12'h040, 32'h1, 32'h2, 32'h7fff, 32'h1}, '{12'h040, 32'h1, 32'h2, 32'h8000, 32'h2},
        '{12'h080, 32'h3, 32'h4, 32'h10000, 32'h4},
        '{12'hc00 >> 4, 32'h10000, 32'h10000, 32'h10000, 32'h0},
        '{12'h0c0, 32'h7fff, 32'h10000, 32'h10000, 32'h10000},
        '{12'h0d0, 32'h10000, 32'h0, 32'h10000, 32'h10000},
        '{12'h0d0, 32'h8000, 32'h8000, 32'h8000, 32'h0},
        '{12'h0a0, 32'h999a, 32'h8000, 32'h199a, 32'h10000},
        '{12'h0a0, 32'h8000, 32'h8000, 32'h199a, 32'h10000},
        '{12'h0a0, 32'h4ccd, 32'h8000, 32'h199a, 32'h0},
        '{12'h0a0, 32'h8000, 32'h8000, 32'h199a, 32'h0},
        '{12'h0b0, 32'h10000, 32'h8000, 32'hffffe666, 32'h10000}};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [FCL_N_CMP-1:0] limit_level;
    logic [31:0] rd;
    logic err;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;

    always #4 pclk = ~pclk;

    fcl_blocks #(.CYCLE_TICKS(TICKS)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .limit_level(limit_level));

    task automatic conclude();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Request held from setup until the edge that samples pready high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic settle();
        repeat (TICKS + 100) @(posedge pclk);
    endtask

    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            miscompares++;
            conclude();
        end
    end

    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk({31'h0, limit_level[0]}, 32'h0);
        rdchk(12'h0a8, FCL_HYST_RST);
        rdchk(12'h0cc, FCL_ONE);
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset done");
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b1, 12'h0d0, 32'h10000);
        settle();
        rdchk(12'h0dc, 32'h0);
        $display("test inverter done");
        for (int i = 0; i < 12; i++)
        begin
            apb(1'b1, ROWS[i].base, ROWS[i].a);
            apb(1'b1, ROWS[i].base + 12'h4, ROWS[i].b);
            apb(1'b1, ROWS[i].base + 12'h8, ROWS[i].c);
            settle();
            rdchk(ROWS[i].base + 12'hc, ROWS[i].q);
            if (ROWS[i].base[11:5] == 7'h05)
                chk({31'h0, limit_level[ROWS[i].base[4]]}, {31'h0, ROWS[i].q[16]});
        end
        $display("test table done");
        apb(1'b1, 12'h008, 32'h0);
        rdchk(12'h008, FCL_QSTART_MIN);
        apb(1'b1, 12'h00c, 32'h7fffffff);
        rdchk(12'h00c, FCL_QEND_MAX);
        apb(1'b1, 12'h008, FCL_ONE);
        apb(1'b1, 12'h00c, 32'h40000);
        apb(1'b1, 12'h018, 32'h8000);
        apb(1'b1, 12'h01c, FCL_ONE);
        apb(1'b1, 12'h020, 32'h0);
        settle();
        rdchk(12'h024, FCL_ONE);
        apb(1'b1, 12'h018, 32'hffff0000);
        settle();
        rdchk(12'h024, 32'h0);
        $display("test corrector done");
        // Negative temperature term drives the denominator below zero
        apb(1'b1, 12'h018, 32'h8000);
        apb(1'b1, 12'h014, 32'h40000);
        apb(1'b1, 12'h020, 32'hffff0000);
        settle();
        rdchk(12'h024, 32'h0);
        rdchk(12'h004, 32'h2);
        $display("test denominator done");
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        chk({30'h0, limit_level}, 32'h0);
        rdchk(12'h00c, FCL_QUOT_RST);
        rdchk(12'h004, 32'h0);
        $display("test mid-run reset done");
        conclude();
    end
endmodule // tb_flow_correction_and_logic_blocks
